// ---- bench/ec_model.sv ----
/*
  Controller model: one register access at a time on the internal port.
  Assumes the port is sampled on the rising edge of sys_clk.
*/
`timescale 1ns/100ps
module ec_model
  import wake_timer_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] host_rdata,
  output reg_req_t         host_req
);
  initial host_req = '0;

  // one strobe cycle; idle fields inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    host_req <= '{a, 1'b1, 1'b0, d};
    @(posedge sys_clk);
    host_req <= '{~a, 1'b0, 1'b0, ~d};
  endtask

  // read data is taken one edge after the strobe was accepted
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    host_req <= '{a, 1'b0, 1'b1, 16'h0000};
    @(posedge sys_clk);
    host_req <= '{~a, 1'b0, 1'b0, 16'hFFFF};
    @(posedge sys_clk);
    d = host_rdata;
  endtask
endmodule

// ---- bench/tb_hibernation_wake_timer.sv ----
/*
  Self-checking bench of the wake timer, register port driven by ec_model.
  Assumes a shortened coarse step so long counts finish quickly.
*/
`timescale 1ns/100ps
module tb_hibernation_wake_timer
  import wake_timer_pkg::*;
;
  localparam int DIV = 20;
  logic        sys_clk;
  logic        reset_n      = 1'b0;
  logic        sleep_enable = 1'b0;
  logic        clock_required;
  logic        wake_count_event;
  logic [15:0] host_rdata;
  logic [15:0] rv;
  logic [15:0] p;
  logic [31:0] seed = 32'h2B4E;
  reg_req_t    host_req;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          ev_cnt    = 0;
  longint      cyc       = 0;
  longint      ev_cyc    = 0;

  hibernation_wake_timer #(.COARSE_CYCLES(DIV)) u_hibernation_wake_timer (
    .sys_clk(sys_clk), .reset_n(reset_n), .host_req(host_req), .host_rdata(host_rdata),
    .clock_required(clock_required), .sleep_enable(sleep_enable), .wake_count_event(wake_count_event));
  ec_model u_ec_model (.sys_clk(sys_clk), .host_rdata(host_rdata), .host_req(host_req));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // last step lands n periods after the load edge; the tally sees it one edge later
  function automatic longint expiry_cycles(input logic [15:0] n, input int dv);
    return longint'(n) * dv + 1;
  endfunction

  // cycle stamp, event tally, random sleep input
  always @(posedge sys_clk) begin
    cyc          <= cyc + 1;
    seed         <= lfsr(seed);
    sleep_enable <= seed[3];
    if (wake_count_event === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
      ev_cyc <= cyc;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("counts errors=%0d tests=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // load n, expect one event n steps later, then silence at zero
  task automatic expire(input logic [15:0] n, input int dv);
    int     ev0;
    longint t0;
    ev0 = ev_cnt;
    u_ec_model.wr(PRELOAD_OFFSET, n);
    t0 = cyc;
    for (int i = 0; i < n * dv + 20 && ev_cnt == ev0; i++) @(posedge sys_clk);
    check((ev_cyc - t0 >= expiry_cycles(n, dv) - 2) && (ev_cyc - t0 <= expiry_cycles(n, dv) + 2), 1);
    repeat (3 * dv) @(posedge sys_clk);
    check(ev_cnt, ev0 + 1);
    u_ec_model.rd(COUNT_OFFSET, rv);
    check(rv, COUNT_ZERO);
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    // defaults, unmapped address reads zero
    for (int i = 0; i < 4; i++) begin
      u_ec_model.rd(8'(4 * i), rv);
      check(rv, 16'h0000);
    end
    $display("test defaults done");
    p = seed[15:0] | 16'h0100;
    u_ec_model.wr(CONTROL_OFFSET, 16'hFFFF);
    u_ec_model.rd(CONTROL_OFFSET, rv);
    check(rv, 16'h0001);
    u_ec_model.wr(PRELOAD_OFFSET, p);
    u_ec_model.rd(PRELOAD_OFFSET, rv);
    check(rv, p);
    u_ec_model.wr(COUNT_OFFSET, ~p);
    u_ec_model.rd(COUNT_OFFSET, rv);
    check(rv, p);
    $display("test registers done");
    // strobe cycle plus one, then released
    u_ec_model.wr(PRELOAD_OFFSET, 16'h0000);
    @(negedge sys_clk);
    check(clock_required, 1'b1);
    @(negedge sys_clk);
    check(clock_required, 1'b0);
    expire(16'h0001, DIV);
    expire(16'h0002 + seed[1:0], DIV);
    $display("test coarse done");
    // reload mid-count, then zero load freezes the count
    u_ec_model.wr(PRELOAD_OFFSET, 16'h0005);
    repeat (DIV + DIV / 2) @(posedge sys_clk);
    u_ec_model.rd(COUNT_OFFSET, rv);
    check(rv, 16'h0004);
    u_ec_model.wr(PRELOAD_OFFSET, 16'h0006);
    u_ec_model.wr(PRELOAD_OFFSET, 16'h0000);
    p = ev_cnt;
    repeat (10 * DIV) @(posedge sys_clk);
    u_ec_model.rd(COUNT_OFFSET, rv);
    check(rv, 16'h0006);
    check(ev_cnt, p);
    $display("test reload done");
    u_ec_model.wr(CONTROL_OFFSET, 16'h0000);
    expire(16'h0001, FINE_TICK_CYCLES);
    $display("test fine done");
    // reset in mid-count clears everything
    u_ec_model.wr(PRELOAD_OFFSET, 16'h0003);
    @(posedge sys_clk) reset_n <= 1'b0;
    @(posedge sys_clk) reset_n <= 1'b1;
    u_ec_model.rd(PRELOAD_OFFSET, rv);
    check(rv, PRELOAD_RESET);
    u_ec_model.rd(COUNT_OFFSET, rv);
    check(rv, COUNT_RESET);
    $display("test reset done");
    complete_run();
  end

  // run needs about 16k cycles; the 40k limit, two and a half times that, means a hang
  initial begin
    #(40000 * 8);
    error_cnt++;
    complete_run();
  end
endmodule

// ---- logic/hibernation_wake_timer.sv ----
/*
  Hibernation wake timer: 16-bit down counter with fine and coarse steps,
  preload, control and count registers on the internal register port.
  Assumes the register port is synchronous to sys_clk and that the
  always-on time base is derived here from sys_clk by dividers.
*/
`timescale 1ns/100ps
module hibernation_wake_timer
  import wake_timer_pkg::*;
#(
  parameter int COARSE_CYCLES = COARSE_TICK_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire reg_req_t    host_req,
  output logic [15:0]      host_rdata,
  output logic             clock_required,
  input  wire logic        sleep_enable,
  output logic             wake_count_event
);

  logic [15:0] preload_value;
  logic        resolution;
  logic [15:0] count;
  logic        enabled;
  logic        update_pending;
  logic        fine_tick;
  logic        coarse_tick;
  logic        tick;
  logic        load;
  logic        preload_wr;
  logic        control_wr;

  assign preload_wr = host_req.wr && host_req.addr == PRELOAD_OFFSET;
  assign control_wr = host_req.wr && host_req.addr == CONTROL_OFFSET;
  assign load       = preload_wr;

  // slow time base made from sys_clk, realigned on each load
  tick_divider #(.DIV(FINE_TICK_CYCLES)) fine_div (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .restart (load),
    .tick    (fine_tick)
  );

  tick_divider #(.DIV(COARSE_CYCLES)) coarse_div (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .restart (load),
    .tick    (coarse_tick)
  );

  // one is coarse, zero is fine
  assign tick = resolution ? coarse_tick : fine_tick;

  // sleep_enable is deliberately left unread; counting never pauses

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      preload_value <= PRELOAD_RESET;
    end else if (preload_wr) begin
      preload_value <= host_req.wdata;
    end
  end

  // control write lands in the same cycle, no wait state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      resolution <= CONTROL_RESET;
    end else if (control_wr) begin
      resolution <= host_req.wdata[RESOLUTION_BIT];
    end
  end

  // enable state; a load wins over a tick in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enabled <= 1'b0;
    end else if (load) begin
      enabled <= host_req.wdata != COUNT_ZERO;
    end
  end

  // down counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= COUNT_RESET;
    end else if (load && host_req.wdata != COUNT_ZERO) begin
      count <= host_req.wdata;
    end else if (!load && enabled && tick && count != COUNT_ZERO) begin
      count <= count - 1'b1;
    end
  end

  // event pulse on the 1 to 0 step only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_count_event <= 1'b0;
    end else begin
      wake_count_event <= !load && enabled && tick && count == COUNT_ONE;
    end
  end

  // register read data, count is live; unmapped reads zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_rdata <= 16'h0000;
    end else if (host_req.rd) begin
      unique case (host_req.addr)
        PRELOAD_OFFSET: host_rdata <= preload_value;
        CONTROL_OFFSET: host_rdata <= {15'h0000, resolution};
        COUNT_OFFSET:   host_rdata <= count;
        default:        host_rdata <= 16'h0000;
      endcase
    end
  end

  // one extra cycle covers the update reaching the core
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      update_pending <= 1'b0;
    end else begin
      update_pending <= host_req.wr || host_req.rd;
    end
  end

  assign clock_required = host_req.wr || host_req.rd || update_pending;

  // checks
  AST_EVENT_AT_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wake_count_event |-> count == COUNT_ZERO && $past(count) == COUNT_ONE && $past(enabled))
    else $error("wake event without a 1 to 0 step");

  AST_RELOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (preload_wr && host_req.wdata != COUNT_ZERO) |=> count == $past(host_req.wdata) && enabled)
    else $error("nonzero preload did not reload counter");

  AST_DISABLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (preload_wr && host_req.wdata == COUNT_ZERO) |=> !enabled ##1 !wake_count_event)
    else $error("zero preload did not disable counter");

  AST_DECREMENT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!load && enabled && tick && count != COUNT_ZERO) |=> count == $past(count) - 16'h0001)
    else $error("counter did not step down on tick");

  AST_HOLD_WITHOUT_TICK: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!load && !tick) |=> $stable(count))
    else $error("counter moved without a selected tick");

  AST_ZERO_STICKY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (count == COUNT_ZERO && !load) |=> count == COUNT_ZERO && !wake_count_event)
    else $error("counter left zero or fired again without reload");

  AST_CONTROL_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    control_wr |=> resolution == $past(host_req.wdata[RESOLUTION_BIT]))
    else $error("control write not taken in one cycle");

  AST_COUNT_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (host_req.rd && host_req.addr == COUNT_OFFSET) |=> host_rdata == $past(count))
    else $error("count read returned wrong value");

  AST_CLOCK_REQUEST: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clock_required |-> host_req.wr || host_req.rd || $past(host_req.wr || host_req.rd))
    else $error("clock request outside an access");

  AST_PRELOAD_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    preload_wr |=> preload_value == $past(host_req.wdata))
    else $error("preload write not stored");

  AST_EVENT_SINGLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wake_count_event |=> !wake_count_event)
    else $error("wake event lasted more than one cycle");

  AST_EVENT_DISABLED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enabled |=> !wake_count_event)
    else $error("wake event while counter disabled");

  // a broken step mux would let the coarse divider move a fine-mode count
  AST_FINE_STEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!load && !resolution && coarse_tick && !fine_tick) |=> $stable(count))
    else $error("fine mode counter moved on coarse tick");

  COV_FINE_EXPIRY: cover property (@(posedge sys_clk) disable iff (!reset_n)
    wake_count_event && !resolution);
  COV_COARSE_EXPIRY: cover property (@(posedge sys_clk) disable iff (!reset_n)
    wake_count_event && resolution);
  COV_RELOAD_MIDCOUNT: cover property (@(posedge sys_clk) disable iff (!reset_n)
    preload_wr && enabled && count != COUNT_ZERO && host_req.wdata != COUNT_ZERO);
  COV_ZERO_LOAD_MIDCOUNT: cover property (@(posedge sys_clk) disable iff (!reset_n)
    preload_wr && enabled && count != COUNT_ZERO && host_req.wdata == COUNT_ZERO);
  COV_UNMAPPED_READ: cover property (@(posedge sys_clk) disable iff (!reset_n)
    host_req.rd && host_req.addr != PRELOAD_OFFSET && host_req.addr != CONTROL_OFFSET
    && host_req.addr != COUNT_OFFSET);

endmodule

// ---- logic/tick_divider.sv ----
/*
  Cycle divider giving a one-cycle enable pulse every DIV clocks.
  Assumes DIV fits in the divider width and is at least one.
*/
`timescale 1ns/100ps
module tick_divider
  import wake_timer_pkg::*;
#(
  parameter int DIV = 2
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic restart,
  output logic      tick
);

  localparam logic [DIVIDER_WIDTH-1:0] LAST = DIVIDER_WIDTH'(DIV - 1);

  logic [DIVIDER_WIDTH-1:0] phase;

  // restart realigns the phase so a fresh load gets a whole first step
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= '0;
    end else if (restart || phase == LAST) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  assign tick = (phase == LAST) && !restart;

endmodule

// ---- logic/wake_timer_pkg.sv ----
/*
  Shared constants and types of the hibernation wake timer: register
  offsets, field positions, reset values, tick timing and the request
  carrier of the internal register port.
  Assumes a single 125 MHz system clock.
*/
package wake_timer_pkg;

  // register offsets within the instance window
  localparam logic [7:0] PRELOAD_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET   = 8'h08;

  // field layout and reset values
  localparam int          COUNT_WIDTH    = 16;
  localparam int          RESOLUTION_BIT = 0;
  localparam logic [15:0] PRELOAD_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic        CONTROL_RESET  = 1'b0;
  localparam logic [15:0] COUNT_ZERO     = 16'h0000;
  localparam logic [15:0] COUNT_ONE      = 16'h0001;

  // tick timing, times in picoseconds
  localparam longint CLK_PERIOD_PS     = 8000;
  localparam longint FINE_TICK_PS      = 30500000;
  localparam longint COARSE_TICK_PS    = 125000000000;
  localparam int     FINE_TICK_CYCLES  = int'(FINE_TICK_PS / CLK_PERIOD_PS);
  localparam int     COARSE_TICK_CYCLES = int'(COARSE_TICK_PS / CLK_PERIOD_PS);
  localparam int     DIVIDER_WIDTH     = 24;

  // one access on the internal register port
  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } reg_req_t;

endpackage
